/* dv/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, sys_reset_n, wdog_clear, err;
  logic ext_reset_n = 1, low_supply_det = 0, ref_clk_lost = 0, bad_addr_access = 0;
  logic illegal_opcode = 0, halt_exec = 0, enter_debug_exec = 0, halt_permit = 0;
  logic debug_mode_permit = 0, debug_forced_reset_bit = 0, wdog_timeout = 0;
  logic [1:0] watchdog_timeout_select = 2'h1;
  int n_mismatch = 0, compares = 0, n_clear = 0, c0;

  always #12.5 pclk = ~pclk;
  // counted here so a pulse between bus calls is never missed
  always @(posedge pclk) if (wdog_clear === 1'b1) n_clear++;

  reset_cause_status reset_cause_status_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .ext_reset_n(ext_reset_n),
    .low_supply_det(low_supply_det), .ref_clk_lost(ref_clk_lost),
    .bad_addr_access(bad_addr_access), .illegal_opcode(illegal_opcode),
    .halt_exec(halt_exec), .enter_debug_exec(enter_debug_exec), .halt_permit(halt_permit),
    .debug_mode_permit(debug_mode_permit), .debug_forced_reset_bit(debug_forced_reset_bit),
    .watchdog_timeout_select(watchdog_timeout_select), .wdog_timeout(wdog_timeout),
    .sys_reset_n(sys_reset_n), .wdog_clear(wdog_clear));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // held until pready is seen at an edge
    // no cycle cap: only the watchdog ends a wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic drive(input int s, input logic v);
    case (s)
      0: ext_reset_n <= ~v;
      1: low_supply_det <= v;
      2: ref_clk_lost <= v;
      3: bad_addr_access <= v;
      4: illegal_opcode <= v;
      5: halt_exec <= v;
      6: enter_debug_exec <= v;
      7: debug_forced_reset_bit <= v;
      8: wdog_timeout <= v;
      10: begin ext_reset_n <= ~v; bad_addr_access <= v; end
      default: ;
    endcase
  endtask

  // source 9 is a bad write to the cause register
  task automatic cause(input int s, input logic hp, input logic dp, input logic [1:0] sel,
                       input logic rst, input logic [7:0] exp);
    int n;
    n = 0;
    @(posedge pclk);
    halt_permit <= hp;
    debug_mode_permit <= dp;
    watchdog_timeout_select <= sel;
    if (s == 9) apb(1'b1, 12'h000, 32'h12);
    else begin
      @(posedge pclk);
      // pin first, so both sources meet at the same reset entry
      if (s == 10) begin
        drive(0, 1'b1);
        repeat (2) @(posedge pclk);
      end
      drive(s, 1'b1);
      // three cycles so the synchronised pins are seen too
      repeat (3) @(posedge pclk);
      drive(s, 1'b0);
    end
    while (sys_reset_n !== 1'b0 && n < 10) begin @(posedge pclk); n++; end
    chk({31'h0, n < 10}, {31'h0, rst});
    n = 0;
    while (sys_reset_n !== 1'b1 && n < 60) begin @(posedge pclk); n++; end
    chk({31'h0, sys_reset_n}, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, {24'h0, exp});
    $display("test source %0d done", s);
  endtask

  task automatic give_verdict();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    #100us;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h82);
    apb(1'b0, 12'h00C, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    c0 = n_clear;
    apb(1'b1, 12'h000, 32'hAA);
    repeat (3) @(posedge pclk);
    chk(n_clear - c0, 32'h0);
    apb(1'b1, 12'h000, 32'h55);
    apb(1'b1, 12'h000, 32'hAA);
    repeat (3) @(posedge pclk);
    chk(n_clear - c0, 32'h1);
    chk({31'h0, irq}, 32'h0);
    chk({31'h0, sys_reset_n}, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h82);
    apb(1'b1, 12'h008, 32'h3);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'h1, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    $display("test service done");
    cause(4, 0, 0, 1, 1, 8'h10);
    cause(3, 0, 0, 1, 1, 8'h08);
    cause(5, 1, 0, 1, 0, 8'h08);
    cause(5, 0, 0, 1, 1, 8'h10);
    cause(0, 0, 0, 1, 1, 8'h40);
    cause(6, 0, 1, 1, 0, 8'h40);
    cause(6, 0, 0, 1, 1, 8'h10);
    cause(9, 0, 0, 1, 1, 8'h20);
    cause(10, 0, 0, 1, 1, 8'h48);
    cause(7, 0, 0, 1, 1, 8'h00);
    cause(8, 0, 0, 0, 0, 8'h00);
    cause(9, 0, 0, 0, 0, 8'h00);
    cause(2, 0, 0, 1, 1, 8'h04);
    cause(8, 0, 0, 1, 1, 8'h20);
    cause(1, 0, 0, 1, 1, 8'h02);
    give_verdict();
  end
endmodule

/* verilog/reset_cause_cfg.svh */
`ifndef RESET_CAUSE_CFG_SVH
`define RESET_CAUSE_CFG_SVH

// register byte addresses
`define RC_ADDR_RESET_CAUSE 12'h000
`define RC_ADDR_IRQ_STATUS 12'h004
`define RC_ADDR_IRQ_MASK 12'h008

// watchdog service values
`define RC_SVC_FIRST 8'h55
`define RC_SVC_SECOND 8'hAA

// reset cause flag bit positions
`define RC_BIT_POWER_UP 7
`define RC_BIT_EXT_PIN 6
`define RC_BIT_WATCHDOG 5
`define RC_BIT_BAD_OPCODE 4
`define RC_BIT_BAD_ADDRESS 3
`define RC_BIT_REF_FAILURE 2
`define RC_BIT_LOW_SUPPLY 1

// flag patterns
`define RC_FLAGS_POWER_ON 8'h82
`define RC_FLAGS_LOW_SUPPLY 8'h02
`define RC_FLAGS_REF_FAILURE 8'h04
`define RC_FLAGS_NONE 8'h00

// interrupt status bits
`define RC_IRQ_BIT_SERVICED 0
`define RC_IRQ_BIT_RESET_TAKEN 1
`define RC_IRQ_RESET 2'h0

// reset pulse stretch, least time
`define RC_CLK_PERIOD_NS 25
`define RC_RST_HOLD_NS 400
`define RC_RST_HOLD_CYC ((`RC_RST_HOLD_NS + `RC_CLK_PERIOD_NS - 1) / `RC_CLK_PERIOD_NS)

`endif

/* verilog/reset_cause_pkg.sv */
package reset_cause_pkg;

  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_HOLD = 2'h1
  } seq_state_t;

  typedef logic [7:0] cause_flags_t;
  typedef logic [4:0] hold_count_t;

endpackage

/* verilog/reset_cause_status.sv */
`include "reset_cause_cfg.svh"

module reset_cause_status import reset_cause_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic ext_reset_n,
  input wire logic low_supply_det,
  input wire logic ref_clk_lost,
  input wire logic bad_addr_access,
  input wire logic illegal_opcode,
  input wire logic halt_exec,
  input wire logic enter_debug_exec,
  input wire logic halt_permit,
  input wire logic debug_mode_permit,
  input wire logic debug_forced_reset_bit,
  input wire logic [1:0] watchdog_timeout_select,
  input wire logic wdog_timeout,
  output logic sys_reset_n,
  output logic wdog_clear
);

  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  cause_flags_t flags_ff;
  cause_flags_t nxt_flags;
  seq_state_t state_ff;
  hold_count_t hold_cnt_ff;
  logic sys_reset_n_ff;
  logic armed_ff;
  logic wdog_clear_ff;
  logic [1:0] irq_stat_ff;
  logic [1:0] irq_mask_ff;
  logic [1:0] nxt_irq_stat;
  logic irq_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;

  // pins and the clock monitor are asynchronous, two flops before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // pin idles high; resetting its flops low would fake a pin reset
      sync1_ff <= 3'h1;
      sync2_ff <= 3'h1;
    end else begin
      sync1_ff <= {ref_clk_lost, low_supply_det, ext_reset_n};
      sync2_ff <= sync1_ff;
    end
  end

  logic ext_src;
  logic supply_src;
  logic clk_loss_src;
  assign ext_src = ~sync2_ff[0];
  assign supply_src = sync2_ff[1];
  assign clk_loss_src = sync2_ff[2];

  logic apb_setup;
  logic apb_done;
  logic hit_rc;
  logic hit_stat;
  logic hit_mask;
  logic wr_rc;
  logic wr_first;
  logic wr_second;
  assign apb_setup = psel & ~penable;
  assign apb_done = psel & penable & pready_ff;
  assign hit_rc = (paddr == `RC_ADDR_RESET_CAUSE);
  assign hit_stat = (paddr == `RC_ADDR_IRQ_STATUS);
  assign hit_mask = (paddr == `RC_ADDR_IRQ_MASK);
  assign wr_rc = apb_done & pwrite & hit_rc;
  assign wr_first = wr_rc & (pwdata[7:0] == `RC_SVC_FIRST);
  assign wr_second = wr_rc & (pwdata[7:0] == `RC_SVC_SECOND);

  logic wdog_en;
  logic bad_write;
  logic wd_src;
  logic op_src;
  logic any_src;
  logic entry;
  assign wdog_en = |watchdog_timeout_select;
  assign bad_write = wr_rc & wdog_en & ~wr_first & ~wr_second;
  assign wd_src = (wdog_timeout & wdog_en) | bad_write;
  assign op_src = illegal_opcode | (halt_exec & ~halt_permit)
    | (enter_debug_exec & ~debug_mode_permit);
  assign any_src = debug_forced_reset_bit | ext_src | supply_src | clk_loss_src | wd_src
    | op_src | bad_addr_access;
  // sources are only looked at outside the stretched reset pulse
  assign entry = (state_ff == ST_RUN) & any_src;

  always_comb begin
    if (debug_forced_reset_bit) begin
      nxt_flags = `RC_FLAGS_NONE;
    end else if (supply_src) begin
      nxt_flags = `RC_FLAGS_LOW_SUPPLY;
    end else if (clk_loss_src) begin
      nxt_flags = `RC_FLAGS_REF_FAILURE;
    end else begin
      nxt_flags = `RC_FLAGS_NONE;
      nxt_flags[`RC_BIT_EXT_PIN] = ext_src;
      nxt_flags[`RC_BIT_WATCHDOG] = wd_src;
      nxt_flags[`RC_BIT_BAD_OPCODE] = op_src;
      nxt_flags[`RC_BIT_BAD_ADDRESS] = bad_addr_access;
    end
  end

  // power-on loads 0x82 and every reset entry overwrites all flags; the system reset we issue must not wipe it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= `RC_FLAGS_POWER_ON;
    end else if (entry) begin
      flags_ff <= nxt_flags;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_RUN;
      hold_cnt_ff <= 5'h0;
      sys_reset_n_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_RUN: begin
          if (entry) begin
            state_ff <= ST_HOLD;
            hold_cnt_ff <= 5'(`RC_RST_HOLD_CYC - 1);
            sys_reset_n_ff <= 1'b0;
          end else begin
            sys_reset_n_ff <= 1'b1;
          end
        end
        ST_HOLD: begin
          if (hold_cnt_ff == 5'h0) begin
            state_ff <= ST_RUN;
            sys_reset_n_ff <= 1'b1;
          end else begin
            hold_cnt_ff <= hold_cnt_ff - 5'h1;
          end
        end
        default: begin
          state_ff <= ST_RUN;
        end
      endcase
    end
  end

  // any cause-register write other than 0x55 breaks the pair; a reset disarms it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed_ff <= 1'b0;
      wdog_clear_ff <= 1'b0;
    end else begin
      wdog_clear_ff <= armed_ff & wr_second & ~entry;
      if (entry) begin
        armed_ff <= 1'b0;
      end else if (wr_rc) begin
        armed_ff <= wr_first;
      end
    end
  end

  // read clears only the bits returned, so a set during the access survives
  always_comb begin
    nxt_irq_stat = irq_stat_ff;
    if (apb_done & ~pwrite & hit_stat) begin
      nxt_irq_stat = nxt_irq_stat & ~prdata_ff[1:0];
    end
    nxt_irq_stat[`RC_IRQ_BIT_SERVICED] = nxt_irq_stat[`RC_IRQ_BIT_SERVICED] | wdog_clear_ff;
    nxt_irq_stat[`RC_IRQ_BIT_RESET_TAKEN] = nxt_irq_stat[`RC_IRQ_BIT_RESET_TAKEN] | entry;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= `RC_IRQ_RESET;
      irq_mask_ff <= `RC_IRQ_RESET;
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      if (apb_done & pwrite & hit_mask) begin
        irq_mask_ff <= pwdata[1:0];
      end
      irq_ff <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // no wait states: data and error prepared in setup, ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= apb_setup;
      pslverr_ff <= apb_setup & ~(hit_rc | hit_stat | hit_mask);
      if (apb_setup) begin
        if (hit_rc) begin
          prdata_ff <= {24'h0, flags_ff[7:1], 1'b0};
        end else if (hit_stat) begin
          prdata_ff <= {30'h0, irq_stat_ff};
        end else if (hit_mask) begin
          prdata_ff <= {30'h0, irq_mask_ff};
        end else begin
          prdata_ff <= 32'h0;
        end
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq = irq_ff;
  assign sys_reset_n = sys_reset_n_ff;
  assign wdog_clear = wdog_clear_ff;

  sequence bad_wr_s;
    bad_write && state_ff == ST_RUN;
  endsequence

  sequence hold_s;
    state_ff == ST_HOLD && !sys_reset_n_ff;
  endsequence

  trip_on_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    bad_wr_s |=> hold_s ##0 (flags_ff[`RC_BIT_WATCHDOG] || flags_ff == `RC_FLAGS_NONE
      || flags_ff == `RC_FLAGS_LOW_SUPPLY || flags_ff == `RC_FLAGS_REF_FAILURE))
    else $error("bad write to reset cause did not trip a reset");

  service_pair_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (armed_ff && wr_second && !entry) |=> wdog_clear_ff && $stable(flags_ff))
    else $error("service pair did not clear watchdog");

  service_arm_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_first && !entry) |=> armed_ff ##1 !wdog_clear_ff || armed_ff)
    else $error("first service value not armed");

  debug_clear_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (entry && debug_forced_reset_bit) |=> flags_ff == `RC_FLAGS_NONE)
    else $error("debug forced reset left a flag set");

  low_supply_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (entry && supply_src && !debug_forced_reset_bit) |=> flags_ff == `RC_FLAGS_LOW_SUPPLY)
    else $error("low supply reset flags wrong");

  other_reset_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (entry && !debug_forced_reset_bit && !supply_src && !clk_loss_src) |=>
      flags_ff[7] == 1'b0 && flags_ff[2:1] == 2'h0
      && flags_ff[`RC_BIT_EXT_PIN] == $past(ext_src)
      && flags_ff[`RC_BIT_BAD_ADDRESS] == $past(bad_addr_access))
    else $error("other reset flags wrong");

  wdog_off_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (entry && !wdog_en) |=> !flags_ff[`RC_BIT_WATCHDOG])
    else $error("watchdog flag set while disabled");

  halt_illegal_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_ff == ST_RUN && halt_exec && !halt_permit && !debug_forced_reset_bit
      && !supply_src && !clk_loss_src) |=> flags_ff[`RC_BIT_BAD_OPCODE] ##0 hold_s)
    else $error("halt without permit did not give opcode reset");

  debug_illegal_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_ff == ST_RUN && enter_debug_exec && !debug_mode_permit
      && !debug_forced_reset_bit && !supply_src && !clk_loss_src)
      |=> flags_ff[`RC_BIT_BAD_OPCODE])
    else $error("enter-debug without permit did not give opcode reset");

  ref_loss_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (entry && clk_loss_src && !supply_src && !debug_forced_reset_bit)
      |=> flags_ff == `RC_FLAGS_REF_FAILURE)
    else $error("reference loss flags wrong");

  flags_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !entry |=> $stable(flags_ff))
    else $error("flags changed without a reset");

  bit0_zero_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (apb_setup && hit_rc) |=> !prdata_ff[0])
    else $error("reset cause bit 0 read as one");

  clear_needs_arm_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    wdog_clear_ff |-> $past(armed_ff) && $past(wr_second))
    else $error("watchdog cleared without the service pair");

  run_quiet_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (state_ff == ST_RUN && !entry) |=> sys_reset_n_ff && state_ff == ST_RUN)
    else $error("system reset raised with no source");

  taken_irq_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    entry |=> irq_stat_ff[`RC_IRQ_BIT_RESET_TAKEN])
    else $error("reset taken status not set");

  irq_level_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> irq_ff == (|($past(irq_stat_ff) & $past(irq_mask_ff))))
    else $error("interrupt level does not follow status and mask");

  ready_pulse_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready_ff |=> !pready_ff)
    else $error("ready held longer than one cycle");

  unmapped_err_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (apb_setup && !(hit_rc || hit_stat || hit_mask)) |=> pslverr_ff && pready_ff
      && prdata_ff == 32'h0)
    else $error("unmapped access not refused");

  reset_len_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(state_ff == ST_HOLD) |-> !sys_reset_n_ff [*8] ##[8:9] sys_reset_n_ff)
    else $error("reset pulse length wrong");

endmodule
